// ===== pkg/scan_port_defs.vh
// Constants for the scan port connect-control block.
`ifndef SCAN_PORT_DEFS_VH
`define SCAN_PORT_DEFS_VH
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SHIFT_DR   4'h4
`define TAP_EXIT1_DR   4'h5
`define TAP_PAUSE_DR   4'h6
`define TAP_EXIT2_DR   4'h7
`define TAP_UPD_DR     4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'ha
`define TAP_SHIFT_IR   4'hb
`define TAP_EXIT1_IR   4'hc
`define TAP_PAUSE_IR   4'hd
`define TAP_EXIT2_IR   4'he
`define TAP_UPD_IR     4'hf
`define ADDR_W         10
`define RESET_GLOBAL_ADDRESS      10'h000
`define DISCONNECT_GLOBAL_ADDRESS 10'h3fe
`define SYNC_GLOBAL_ADDRESS       10'h3ff
`define CONN_OFF       2'h0
`define CONN_ON        2'h1
`define CONN_RESET     2'h2
`define CONN_MULTICAST 2'h3
`define RES_NONE       3'h0
`define RES_RESET      3'h1
`define RES_MATCH      3'h2
`define RES_DISCONNECT 3'h3
`define RES_SYNC       3'h4
`define RES_NO_MATCH   3'h5
`define RES_HARD_ERROR 3'h6
`endif

// ===== hw/scan_port_connect_control.v
// Connect-control logic: primary TAP monitor, select receiver, address matcher, acknowledge.
`timescale 1ns/100ps
`include "scan_port_defs.vh"
// How it works
// [R01] Monitor starts in Test-Logic-Reset after power-up.
// [R02] Low test reset forces monitor to Test-Logic-Reset after its two-stage synchroniser, no test clock edge needed.
// [R03] Addressing accepted only in stable Reset, Idle, Pause-DR or Pause-IR.
// [R04] Addressing ignored in every Select, Capture, Shift, Exit or Update state.
// [R05] Sync address honoured only in Pause-DR or Pause-IR.
// [R06] Monitor follows standard TAP diagram on mode-select at test clock rise.
// [R07] Status from last valid address versus board and three global addresses.
// [R08] All-zero address gives RESET result and RESET status.
// [R09] Address 3fe gives DISCONNECT result and OFF status.
// [R10] Address 3ff gives sync result and MULTICAST status in pause states.
// [R11] Any other unmatched address gives NO MATCH and OFF status.
// [R12] On match send acknowledge, then enter ON and route primary to secondary.
// [R13] NO MATCH goes OFF at once, data outputs released, mode-select held.
// [R14] OFF deselects secondary chain without disturbing its TAP state.
// [R15] Disconnect code enters OFF at once, no acknowledge.
// [R16] Master disconnects, moves primary state, then selects differing chain.
// [R17] Bit pairs: high-high idle, low-low select, low-high one, high-low zero.
// [R18] Ten address bits least significant first, framed by idle and select.
// [R19] TAP state change mid-protocol aborts and resets the receiver.
// [R20] Connect status holds until the next complete protocol, a hard error or a test reset.
// [R21] Board address sampled at the moment of comparison.
module scan_port_connect_control (
  input wire clock,
  input wire rst_b,
  input wire primary_test_clock,
  input wire primary_test_reset_n,
  input wire primary_mode_select,
  input wire primary_serial_in,
  input wire secondary_serial_in,
  input wire [9:0] board_address_inputs,
  output reg primary_serial_out_q,
  output reg primary_serial_out_oe_q,
  output reg secondary_serial_out_q,
  output reg secondary_serial_out_oe_q,
  output reg secondary_mode_select_q,
  output reg [1:0] connect_status_q,
  output reg [2:0] protocol_result_q,
  output reg [3:0] tap_state_q
);
////////////////////////////////////////////////////////////////////////////////
reg [2:0] tck_sync_q;
reg [1:0] trst_sync_q;
reg [1:0] tms_sync_q;
reg [1:0] tdi_sync_q;
reg [1:0] sin_sync_q;
reg [9:0] addr_sync1_q;
reg [9:0] addr_sync2_q;
wire tck_rise;
wire tck_fall;
wire trst_n;
wire tms;
wire tdi;
assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
assign trst_n = trst_sync_q[1];
assign tms = tms_sync_q[1];
assign tdi = tdi_sync_q[1];

always @(posedge clock or negedge rst_b) begin
  if (!rst_b) begin
    tck_sync_q <= 3'h0;
    trst_sync_q <= 2'h3;
    tms_sync_q <= 2'h3;
    tdi_sync_q <= 2'h3;
    sin_sync_q <= 2'h3;
    addr_sync1_q <= 10'h000;
    addr_sync2_q <= 10'h000;
  end else begin
    tck_sync_q <= {tck_sync_q[1:0], primary_test_clock};
    trst_sync_q <= {trst_sync_q[0], primary_test_reset_n};
    tms_sync_q <= {tms_sync_q[0], primary_mode_select};
    tdi_sync_q <= {tdi_sync_q[0], primary_serial_in};
    sin_sync_q <= {sin_sync_q[0], secondary_serial_in};
    addr_sync1_q <= board_address_inputs;
    addr_sync2_q <= addr_sync1_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Standard TAP next-state function.
function [3:0] tap_next;
  input [3:0] s;
  input m;
  begin
    case (s)
      `TAP_RESET: tap_next = m ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: tap_next = m ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: tap_next = m ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: tap_next = m ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: tap_next = m ? `TAP_UPD_DR : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: tap_next = m ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: tap_next = m ? `TAP_UPD_DR : `TAP_SHIFT_DR;
      `TAP_UPD_DR: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: tap_next = m ? `TAP_RESET : `TAP_CAP_IR;
      `TAP_CAP_IR: tap_next = m ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: tap_next = m ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: tap_next = m ? `TAP_UPD_IR : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: tap_next = m ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: tap_next = m ? `TAP_UPD_IR : `TAP_SHIFT_IR;
      default: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
    endcase
  end
endfunction

// True for the four states in which the monitor may rest.
function stable_state;
  input [3:0] s;
  begin
    stable_state = (s == `TAP_RESET) | (s == `TAP_IDLE) |
                   (s == `TAP_PAUSE_DR) | (s == `TAP_PAUSE_IR);
  end
endfunction

wire [3:0] tap_d;
wire stays;
wire enabled;
wire in_pause;
assign tap_d = tap_next(tap_state_q, tms); // [R06]
assign stays = (tap_d == tap_state_q);
assign enabled = stable_state(tap_state_q) & stays & trst_n; // [R03] [R04]
assign in_pause = (tap_state_q == `TAP_PAUSE_DR) | (tap_state_q == `TAP_PAUSE_IR);

always @(posedge clock or negedge rst_b) begin
  if (!rst_b) begin
    tap_state_q <= `TAP_RESET; // [R01]
  end else if (!trst_n) begin
    tap_state_q <= `TAP_RESET; // [R02]
  end else if (tck_rise) begin
    tap_state_q <= tap_d; // [R06]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Select receiver and acknowledge transmitter.
localparam RX_IDLE = 3'h0;
localparam RX_SEL = 3'h1;
localparam RX_DATA = 3'h2;
localparam RX_END = 3'h3;
localparam TX_RUN = 3'h4;

reg [2:0] rx_q;
reg half_q;
reg first_q;
reg [9:0] addr_q;
reg [4:0] cnt_q;
reg all1_q;
reg all0_q;
reg [3:0] tx_idx_q;
reg [29:0] ack_bits_q;

// Acknowledge frame I S D*10 S I I as a 30-bit level stream, LSB sent first.
function [29:0] ack_frame;
  input [9:0] a;
  integer i;
  begin
    ack_frame = 30'h0;
    ack_frame[1:0] = 2'h3;
    ack_frame[3:2] = 2'h0;
    for (i = 0; i < 10; i = i + 1) begin
      ack_frame[4 + 2 * i] = ~a[i]; // [R17] [R18]
      ack_frame[5 + 2 * i] = a[i];
    end
    ack_frame[25:24] = 2'h0;
    ack_frame[27:26] = 2'h3;
    ack_frame[29:28] = 2'h3;
  end
endfunction

wire [1:0] pair;
assign pair = {first_q, tdi};

always @(posedge clock or negedge rst_b) begin
  if (!rst_b) begin
    rx_q <= RX_IDLE;
    half_q <= 1'b0;
    first_q <= 1'b1;
    addr_q <= 10'h000;
    cnt_q <= 5'h00;
    all1_q <= 1'b1;
    all0_q <= 1'b1;
    tx_idx_q <= 4'h0;
    ack_bits_q <= 30'h0;
    connect_status_q <= `CONN_OFF;
    protocol_result_q <= `RES_NONE;
    primary_serial_out_q <= 1'b1;
    primary_serial_out_oe_q <= 1'b0;
    secondary_serial_out_q <= 1'b1;
    secondary_serial_out_oe_q <= 1'b0;
    secondary_mode_select_q <= 1'b1;
  end else if (!trst_n) begin
    rx_q <= RX_IDLE;
    half_q <= 1'b0;
    connect_status_q <= `CONN_RESET;
    primary_serial_out_oe_q <= 1'b0;
    secondary_serial_out_oe_q <= 1'b0;
    secondary_mode_select_q <= 1'b1;
  end else begin
    // Output routing follows the connect status; serial data changes on the falling edge.
    case (connect_status_q)
      `CONN_ON: begin
        secondary_mode_select_q <= tms; // [R12]
        secondary_serial_out_oe_q <= 1'b1;
        if (rx_q != TX_RUN) begin
          primary_serial_out_oe_q <= 1'b1;
          if (tck_fall) primary_serial_out_q <= sin_sync_q[1];
        end
        if (tck_fall) secondary_serial_out_q <= tdi;
      end
      `CONN_MULTICAST: begin
        secondary_mode_select_q <= tms;
        secondary_serial_out_oe_q <= 1'b1;
        if (rx_q != TX_RUN) primary_serial_out_oe_q <= 1'b0;
        if (tck_fall) secondary_serial_out_q <= tdi;
      end
      `CONN_RESET: begin
        secondary_mode_select_q <= 1'b1;
        secondary_serial_out_oe_q <= 1'b0;
        if (rx_q != TX_RUN) primary_serial_out_oe_q <= 1'b0;
      end
      default: begin
        secondary_serial_out_oe_q <= 1'b0; // [R13] [R14]
        if (rx_q != TX_RUN) primary_serial_out_oe_q <= 1'b0;
      end
    endcase
    if (tck_rise) begin
      if (rx_q == TX_RUN) begin
        if (!stays || !stable_state(tap_state_q)) begin
          rx_q <= RX_IDLE; // [R19]
          protocol_result_q <= `RES_HARD_ERROR;
          connect_status_q <= `CONN_OFF;
          primary_serial_out_oe_q <= 1'b0;
        end else if (half_q && tx_idx_q == 4'he) begin
          rx_q <= RX_IDLE;
          half_q <= 1'b0;
          primary_serial_out_oe_q <= 1'b0;
          connect_status_q <= `CONN_ON; // [R12]
        end else begin
          half_q <= ~half_q;
          if (half_q) tx_idx_q <= tx_idx_q + 4'h1;
        end
      end else if (!enabled) begin
        if (rx_q == RX_DATA || rx_q == RX_END) begin
          protocol_result_q <= `RES_HARD_ERROR; // [R19]
          connect_status_q <= `CONN_OFF;
        end
        rx_q <= RX_IDLE; // [R04] [R19]
        half_q <= 1'b0;
      end else if (!half_q) begin
        first_q <= tdi;
        half_q <= 1'b1;
      end else begin
        half_q <= 1'b0;
        case (rx_q)
          RX_IDLE: if (pair == 2'h0) begin
            rx_q <= RX_SEL;
            cnt_q <= 5'h00;
            addr_q <= 10'h000;
            all1_q <= 1'b1;
            all0_q <= 1'b1;
          end else if (pair == 2'h3) begin
            rx_q <= RX_IDLE;
          end else begin
            half_q <= 1'b1; // Realign pair framing on a stray data pair.
            first_q <= tdi;
          end
          RX_SEL, RX_DATA: begin
            if (pair == 2'h1 || pair == 2'h2) begin
              rx_q <= RX_DATA;
              if (cnt_q < 5'd10) addr_q[cnt_q[3:0]] <= (pair == 2'h1); // [R18]
              if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
              all1_q <= all1_q & (pair == 2'h1);
              all0_q <= all0_q & (pair == 2'h2);
            end else if (pair == 2'h0) begin
              rx_q <= (rx_q == RX_DATA) ? RX_END : RX_SEL;
            end else begin
              if (rx_q == RX_DATA) begin
                protocol_result_q <= `RES_HARD_ERROR;
                connect_status_q <= `CONN_OFF;
              end
              rx_q <= RX_IDLE;
            end
          end
          RX_END: begin
            rx_q <= RX_IDLE;
            if (pair != 2'h3) begin
              protocol_result_q <= `RES_HARD_ERROR;
              connect_status_q <= `CONN_OFF;
            end else if (all0_q && cnt_q >= 5'd10) begin
              protocol_result_q <= `RES_RESET; // [R07] [R08]
              connect_status_q <= `CONN_RESET;
            end else if (all1_q && cnt_q >= 5'd10) begin
              if (in_pause) begin
                protocol_result_q <= `RES_SYNC; // [R05] [R10]
                connect_status_q <= `CONN_MULTICAST;
              end else begin
                protocol_result_q <= `RES_DISCONNECT; // [R05]
                connect_status_q <= `CONN_OFF;
              end
            end else if (cnt_q != 5'd10) begin
              protocol_result_q <= `RES_HARD_ERROR;
              connect_status_q <= `CONN_OFF;
            end else if (addr_q == `DISCONNECT_GLOBAL_ADDRESS) begin
              protocol_result_q <= `RES_DISCONNECT; // [R09] [R15]
              connect_status_q <= `CONN_OFF;
            end else if (addr_q == addr_sync2_q) begin // [R21]
              protocol_result_q <= `RES_MATCH;
              connect_status_q <= `CONN_OFF;
              rx_q <= TX_RUN; // [R12]
              tx_idx_q <= 4'h0;
              ack_bits_q <= ack_frame(addr_q);
              primary_serial_out_oe_q <= 1'b1;
            end else begin
              protocol_result_q <= `RES_NO_MATCH; // [R11] [R13]
              connect_status_q <= `CONN_OFF;
            end
          end
          default: rx_q <= RX_IDLE;
        endcase
      end
    end
    // Acknowledge levels change on the falling test clock edge.
    if (rx_q == TX_RUN && tck_fall) begin
      primary_serial_out_q <= ack_bits_q[{tx_idx_q, 1'b0} + {4'h0, half_q}]; // [R17]
    end
  end
end

endmodule // scan_port_connect_control

// ===== tb/scan_port_sva.sv
// Assertion checker for the scan port connect-control block.
`timescale 1ns/100ps
`include "scan_port_defs.vh"
module scan_port_sva (
  input wire clock,
  input wire rst_b,
  input wire primary_test_reset_n,
  input wire primary_serial_out_oe_q,
  input wire secondary_serial_out_oe_q,
  input wire secondary_mode_select_q,
  input wire [1:0] connect_status_q,
  input wire [2:0] protocol_result_q,
  input wire [3:0] tap_state_q
);
  wire [1:0] st = connect_status_q;
  wire [2:0] res = protocol_result_q;
  wire pause = tap_state_q == `TAP_PAUSE_DR || tap_state_q == `TAP_PAUSE_IR;
  wire calm = pause || tap_state_q == `TAP_RESET || tap_state_q == `TAP_IDLE;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_power_up_reset:
    assert property ($rose(rst_b) |-> tap_state_q == `TAP_RESET) else $error("bad state");
  a_test_reset:
    assert property ($fell(primary_test_reset_n) |-> ##[1:4] tap_state_q == `TAP_RESET)
    else $error("test reset ignored");
  a_window_states:
    assert property ($changed(res) && res != `RES_HARD_ERROR |-> calm)
    else $error("result outside stable state");
  a_sync_pause:
    assert property ($changed(res) && res == `RES_SYNC |-> pause && st == `CONN_MULTICAST)
    else $error("bad sync");
  a_reset_code:
    assert property ($changed(res) && res == `RES_RESET |-> st == `CONN_RESET)
    else $error("bad reset status");
  a_disconnect_off:
    assert property ($changed(res) && res == `RES_DISCONNECT |-> st == `CONN_OFF)
    else $error("bad disconnect status");
  a_no_match_off:
    assert property ($changed(res) && res == `RES_NO_MATCH |->
      st == `CONN_OFF ##1 !primary_serial_out_oe_q) else $error("bad no match");
  a_off_holds:
    assert property (st == `CONN_OFF && $past(st) == `CONN_OFF && $past(st, 2) == `CONN_OFF
      |-> $stable(secondary_mode_select_q) && !secondary_serial_out_oe_q)
    else $error("off state disturbed chain");
  a_on_after_ack:
    assert property (st == `CONN_ON && $past(st) != `CONN_ON |->
      res == `RES_MATCH && $past(primary_serial_out_oe_q)) else $error("on without ack");
endmodule // scan_port_sva
bind scan_port_connect_control scan_port_sva scan_port_sva_i (.clock(clock), .rst_b(rst_b),
  .primary_test_reset_n(primary_test_reset_n),
  .primary_serial_out_oe_q(primary_serial_out_oe_q),
  .secondary_serial_out_oe_q(secondary_serial_out_oe_q),
  .secondary_mode_select_q(secondary_mode_select_q), .connect_status_q(connect_status_q),
  .protocol_result_q(protocol_result_q), .tap_state_q(tap_state_q));

// ===== tb/scan_master.sv
// Behavioural test bus master driving the primary test port.
`timescale 1ns/100ps
module scan_master (
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One clock period; walk, idle and frame each end on a high data bit, the pulled-up idle level.
  task automatic clk(input logic d);
    begin
      tdi = d;
      #62.5 tck = 1'b1;
      #62.5 tck = 1'b0;
    end
  endtask
  task automatic walk(input logic [7:0] p, input int n);
    begin
      for (int i = 0; i < n; i++) begin
        tms = p[i];
        clk(1'b1);
      end
    end
  endtask
  task automatic idle(input int n);
    begin
      repeat (n) clk(1'b1);
    end
  endtask
  // Mode select stays put for the whole frame.
  task automatic frame(input logic [9:0] a);
    begin
      clk(1'b1);
      clk(1'b1);
      clk(1'b0);
      clk(1'b0);
      for (int i = 0; i < 10; i++) begin
        clk(!a[i]);
        clk(a[i]);
      end
      clk(1'b0);
      clk(1'b0);
      clk(1'b1);
      clk(1'b1);
    end
  endtask
endmodule // scan_master

// ===== tb/test_scan_port_connect_control.sv
// Self-checking bench for the scan port connect-control block.
`timescale 1ns/100ps
`include "scan_port_defs.vh"
module test_scan_port_connect_control;
  typedef struct packed {
    logic [9:0] a;
    logic [9:0] board;
    logic [3:0] tap;
    logic [1:0] st;
    logic [2:0] res;
  } row_t;
  logic clock;
  logic rst_b;
  logic trst_n;
  logic sin;
  logic [9:0] board;
  wire tck, tms, tdi, pso, pso_oe, sso, sso_oe, sms;
  wire [1:0] st;
  wire [2:0] res;
  wire [3:0] tap;
  int n_errors = 0;
  int checks = 0;
  row_t row;
  row_t rows [11] = '{
    '{10'h000, 10'h155, `TAP_RESET, `CONN_RESET, `RES_RESET},
    '{10'h3fe, 10'h155, `TAP_IDLE, `CONN_OFF, `RES_DISCONNECT},
    '{10'h3ff, 10'h155, `TAP_PAUSE_DR, `CONN_MULTICAST, `RES_SYNC},
    '{10'h3ff, 10'h155, `TAP_IDLE, `CONN_OFF, `RES_DISCONNECT},
    '{10'h3ff, 10'h155, `TAP_PAUSE_IR, `CONN_MULTICAST, `RES_SYNC},
    '{10'h3ff, 10'h155, `TAP_RESET, `CONN_OFF, `RES_DISCONNECT},
    '{10'h123, 10'h155, `TAP_IDLE, `CONN_OFF, `RES_NO_MATCH},
    '{10'h2aa, 10'h2aa, `TAP_RESET, `CONN_ON, `RES_MATCH},
    '{10'h3fe, 10'h2aa, `TAP_PAUSE_DR, `CONN_OFF, `RES_DISCONNECT},
    '{10'h000, 10'h2aa, `TAP_PAUSE_IR, `CONN_RESET, `RES_RESET},
    '{10'h155, 10'h155, `TAP_PAUSE_DR, `CONN_ON, `RES_MATCH}};
  scan_master scan_master_i (.tck(tck), .tms(tms), .tdi(tdi));
  scan_port_connect_control scan_port_connect_control_i (.clock(clock), .rst_b(rst_b),
    .primary_test_clock(tck), .primary_test_reset_n(trst_n), .primary_mode_select(tms),
    .primary_serial_in(tdi), .secondary_serial_in(sin), .board_address_inputs(board),
    .primary_serial_out_q(pso), .primary_serial_out_oe_q(pso_oe),
    .secondary_serial_out_q(sso), .secondary_serial_out_oe_q(sso_oe),
    .secondary_mode_select_q(sms), .connect_status_q(st), .protocol_result_q(res),
    .tap_state_q(tap));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    begin
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    begin
      checks++;
      if (seen !== exp) begin
        n_errors++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic wait_st(input logic [1:0] e);
    int k;
    begin
      for (k = 0; k < 40 && st !== e; k++) @(posedge clock);
      if (k == 40) begin
        n_errors++;
        results();
      end
    end
  endtask
  task automatic go(input logic [3:0] t);
    begin
      scan_master_i.walk(8'h1f, 5);
      case (t)
        `TAP_IDLE: scan_master_i.walk(8'h00, 1);
        `TAP_PAUSE_DR: scan_master_i.walk(8'h0a, 5);
        `TAP_PAUSE_IR: scan_master_i.walk(8'h16, 6);
        default: ;
      endcase
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    trst_n = 1'b1;
    sin = 1'b1;
    board = 10'h155;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check(tap, `TAP_RESET);
    for (int r = 0; r < 11; r++) begin
      row = rows[r];
      go(row.tap);
      @(posedge clock);
      board <= row.board;
      repeat (4) @(posedge clock);
      check(tap, row.tap);
      scan_master_i.frame(row.a);
      repeat (8) @(posedge clock);
      if (row.st == `CONN_ON) begin
        check({pso_oe, st == `CONN_ON}, 2'b10);
      end else begin
        check(st, row.st);
      end
      scan_master_i.idle(34);
      wait_st(row.st);
      check(st, row.st);
      check(res, row.res);
    end
    @(posedge clock);
    sin <= 1'b0;
    scan_master_i.idle(1);
    repeat (8) @(posedge clock);
    check({pso, pso_oe, sso, sso_oe, sms}, 5'h0e);
    sin <= 1'b1;
    scan_master_i.walk(8'h01, 2);
    repeat (6) @(posedge clock);
    check(tap, `TAP_SHIFT_DR);
    scan_master_i.frame(`DISCONNECT_GLOBAL_ADDRESS);
    scan_master_i.idle(4);
    repeat (6) @(posedge clock);
    check({st, res}, {`CONN_ON, `RES_MATCH});
    scan_master_i.walk(8'h03, 3);
    scan_master_i.frame(10'h0aa);
    repeat (8) @(posedge clock);
    check(st, `CONN_OFF);
    scan_master_i.walk(8'h1f, 5);
    repeat (6) @(posedge clock);
    check({sms, sso_oe, pso_oe}, 3'h0);
    scan_master_i.walk(8'h00, 1);
    for (int i = 0; i < 6; i++) scan_master_i.clk(i < 2 || i == 5);
    scan_master_i.walk(8'h01, 1);
    repeat (6) @(posedge clock);
    check({st, res}, {`CONN_OFF, `RES_HARD_ERROR});
    @(posedge clock);
    trst_n <= 1'b0;
    repeat (6) @(posedge clock);
    check({tap, st, sms}, {`TAP_RESET, `CONN_RESET, 1'b1});
    trst_n <= 1'b1;
    repeat (4) @(posedge clock);
    scan_master_i.walk(8'h00, 1);
    repeat (6) @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    check({tap, st}, {`TAP_RESET, `CONN_OFF});
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check({tap, st, res}, {`TAP_RESET, `CONN_OFF, `RES_NONE});
    results();
  end
endmodule // test_scan_port_connect_control
